/* src/brt_consts.svh */
// Register offsets, field positions, reset values and counts of the tester.
// Assumes a word-wide register port; offsets are byte addresses.
`ifndef BRT_CONSTS_SVH
`define BRT_CONSTS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define BRT_ADDR_W          8
`define BRT_OFS_ROUTE       8'h00
`define BRT_OFS_PCFG        8'h04
`define BRT_OFS_SEED_LO     8'h08
`define BRT_OFS_SEED_HI     8'h0C
`define BRT_OFS_CTRL        8'h10
`define BRT_OFS_STATUS      8'h14
`define BRT_OFS_BIT_CNT     8'h18
`define BRT_OFS_ERR_CNT     8'h1C

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define BRT_ROUTE_EN        0
`define BRT_PCFG_LEN_LSB    0
`define BRT_PCFG_PTS        5
`define BRT_PCFG_QRSS       6
`define BRT_PCFG_TAP_LSB    8
`define BRT_CTRL_TX_LOAD    0
`define BRT_CTRL_RX_LOAD    1
`define BRT_CTRL_LATCH      2
`define BRT_CTRL_TX_INV     3
`define BRT_CTRL_RX_INV     4
`define BRT_CTRL_ONE_ERR    5
`define BRT_CTRL_ERR_PIN    6
`define BRT_CTRL_NO_RESYNC  7
`define BRT_CTRL_RATE_LSB   8
`define BRT_STAT_BIT_ERR    0
`define BRT_STAT_OOS        1

// ----------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------
`define BRT_PCFG_RST        13'h0000
`define BRT_SEED_RST        16'hFFFF
`define BRT_CTRL_RST        11'h000
`define BRT_SYNC_BITS       6'h20
`define BRT_WIN_LAST        6'h3F
`define BRT_LOSS_ERRS       3'h6
`define BRT_QRSS_ZERO_BITS  14
`define BRT_RATE_1          24'h000009
`define BRT_RATE_2          24'h000063
`define BRT_RATE_3          24'h0003E7
`define BRT_RATE_4          24'h00270F
`define BRT_RATE_5          24'h01869F
`define BRT_RATE_6          24'h0F423F
`define BRT_RATE_7          24'h98967F

`endif

/* src/brt_pkg.sv */
// Types used by the tester; its bench does not import them.
// Assumes brt_consts.svh for every number.
package brt_pkg;

	// Receive synchronisation states
	typedef enum logic [1:0]
	{
		BRT_SEARCH,
		BRT_VERIFY,
		BRT_SYNC
	} brt_sync_e;

endpackage

/* src/brt_tester.sv */
// Bit error-rate tester: pattern generator, error insertion and checker.
// Assumes one 125 MHz clock, bit strobes from same-clock line logic and
// a simple strobed register port; the manual error pin is asynchronous.
//
// What this block does
// - Nothing generates or monitors until the enable bit is set.
// - New pattern and seed settings apply only on a rising load bit, per direction.
// - Bit-error flag reads one while the error counter is nonzero.
// - Latch update copies both running counters out, then clears them.
// - Generators are 32-bit shifters; feedback enters bit 1 and is output.
// - Feedback is bit n xor bit y, or bit n when repetitive.
// - QRSS feeds back bits 17 xor 20; output one after 14 zeros.
// - Pseudorandom feedback forced to one when bits 1 to 31 are zero.
// - Receiver loads 32 bits, then needs 32 matching bits for sync.
// - Six mismatches in a 64-bit window restart sync unless disabled.
// - Repetitive sync searches bit positions, then needs 32 matches.
// - Out-of-sync flag follows the sync state one clock late: set after leaving it, cleared after entering it.
// - Every bit compared in sync counts; a mismatch also counts an error.
// - Counters hold while out of sync.
// - Transmit generator is preset with the seed on a new load.
// - Rate insertion flips one bit in 10^n, n 1 to 7, or off.
// - Single errors come from a register write or the manual pin.
// - Optional inversion of the outgoing pattern stream.
// - Latched error count is 24 bits, latched bit count 32 bits.
//
// Our own choices: strobed register access and the register addresses.
`timescale 1ns/1ps
`include "brt_consts.svh"

module brt_tester
	import brt_pkg::*;
#(
	parameter int DATA_W = 32,
	parameter int BCNT_W = 32,
	parameter int ECNT_W = 24
)
(
	input  wire logic                   i_clk,
	input  wire logic                   i_rstn,
	input  wire logic [`BRT_ADDR_W-1:0] i_addr,
	input  wire logic [DATA_W-1:0]      i_wdata,
	input  wire logic                   i_wr,
	input  wire logic                   i_rd,
	output logic      [DATA_W-1:0]      o_rdata,
	input  wire logic                   i_tx_bit_en,
	output logic                        o_tx_data,
	output logic                        o_tx_valid,
	input  wire logic                   i_rx_bit_en,
	input  wire logic                   i_rx_data,
	input  wire logic                   i_manual_error_input,
	output logic                        o_out_of_sync_flag
);

	// ----------------------------------------------------------------
	// Pattern generator functions
	// ----------------------------------------------------------------
	// Feedback of a 32-bit generator; bit k of the text is g[k-1]
	function automatic logic brt_fb(input logic [31:0] g,
		input logic [4:0] len, input logic [4:0] tap,
		input logic pattern_type_select, input logic qrss);
		logic f;
		f = 1'b0;
		if (pattern_type_select)
			f = g[len];
		else if (qrss)
			f = g[16] ^ g[19];
		else
			f = g[len] ^ g[tap];
		if (!pattern_type_select && g[30:0] == 31'h00000000)
			f = 1'b1;
		return f;
	endfunction

	// Output bit: feedback, but QRSS forces one over a long zero run
	function automatic logic brt_out(input logic [31:0] g,
		input logic [4:0] len, input logic [4:0] tap,
		input logic pattern_type_select, input logic qrss);
		logic o;
		o = brt_fb(g, len, tap, pattern_type_select, qrss);
		if (!pattern_type_select && qrss && g[`BRT_QRSS_ZERO_BITS-1:0] == 14'h0000)
			o = 1'b1;
		return o;
	endfunction

	// Period minus one for rate-based insertion
	function automatic logic [23:0] brt_period(input logic [2:0] r);
		logic [23:0] p;
		p = `BRT_RATE_1;
		case (r)
			3'h2: p = `BRT_RATE_2;
			3'h3: p = `BRT_RATE_3;
			3'h4: p = `BRT_RATE_4;
			3'h5: p = `BRT_RATE_5;
			3'h6: p = `BRT_RATE_6;
			3'h7: p = `BRT_RATE_7;
			default: p = `BRT_RATE_1;
		endcase
		return p;
	endfunction

	// ----------------------------------------------------------------
	// Software registers
	// ----------------------------------------------------------------
	logic              enable;
	logic [12:0]       pcfg;
	logic [15:0]       seed_low_half;
	logic [15:0]       seed_high_half;
	logic [10:0]       ctrl;
	logic              one_err_req;
	logic              tx_load_pls;
	logic              rx_load_pls;
	logic              latch_pls;
	logic [BCNT_W-1:0] rx_bit_count_reg;
	logic [ECNT_W-1:0] rx_error_count_reg;

	// Decode of the strobed port
	wire wr_route = i_wr && i_addr == `BRT_OFS_ROUTE;
	wire wr_pcfg  = i_wr && i_addr == `BRT_OFS_PCFG;
	wire wr_slo   = i_wr && i_addr == `BRT_OFS_SEED_LO;
	wire wr_shi   = i_wr && i_addr == `BRT_OFS_SEED_HI;
	wire wr_ctrl  = i_wr && i_addr == `BRT_OFS_CTRL;
	wire [10:0] wctl = i_wdata[10:0];

	// Write side; load and latch bits act on a zero-to-one change only
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			enable         <= 1'b0;
			pcfg           <= `BRT_PCFG_RST;
			seed_low_half  <= `BRT_SEED_RST;
			seed_high_half <= `BRT_SEED_RST;
			ctrl           <= `BRT_CTRL_RST;
			tx_load_pls    <= 1'b0;
			rx_load_pls    <= 1'b0;
			latch_pls      <= 1'b0;
			one_err_req    <= 1'b0;
		end
		else
		begin
			if (wr_route)
				enable <= i_wdata[`BRT_ROUTE_EN];
			if (wr_pcfg)
				pcfg <= i_wdata[12:0];
			if (wr_slo)
				seed_low_half <= i_wdata[15:0];
			if (wr_shi)
				seed_high_half <= i_wdata[15:0];
			if (wr_ctrl)
				ctrl <= wctl;
			tx_load_pls <= wr_ctrl && wctl[`BRT_CTRL_TX_LOAD]
				&& !ctrl[`BRT_CTRL_TX_LOAD];
			rx_load_pls <= wr_ctrl && wctl[`BRT_CTRL_RX_LOAD]
				&& !ctrl[`BRT_CTRL_RX_LOAD];
			latch_pls <= wr_ctrl && wctl[`BRT_CTRL_LATCH]
				&& !ctrl[`BRT_CTRL_LATCH];
			one_err_req <= wr_ctrl && wctl[`BRT_CTRL_ONE_ERR];
		end
	end

	// Working pattern settings, captured only at a load
	logic [12:0] tx_cfg;
	logic [12:0] rx_cfg;
	logic [31:0] rx_seed;
	wire  [31:0] seed = {seed_high_half, seed_low_half};

	// ----------------------------------------------------------------
	// Manual error pin
	// ----------------------------------------------------------------
	logic pin_s1;
	logic pin_s2;
	logic pin_s3;
	logic pin_lvl;
	// Change accepted only once the last two stages agree
	wire pin_rise = pin_s2 && pin_s3 && !pin_lvl;

	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			pin_s1  <= 1'b0;
			pin_s2  <= 1'b0;
			pin_s3  <= 1'b0;
			pin_lvl <= 1'b0;
		end
		else
		begin
			pin_s1 <= i_manual_error_input;
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
			if (pin_s2 == pin_s3)
				pin_lvl <= pin_s2;
		end
	end

	// ----------------------------------------------------------------
	// Transmit generator and error insertion
	// ----------------------------------------------------------------
	logic [31:0] tx_gen;
	logic [23:0] rate_cnt;
	logic        err_pend;
	wire  [2:0]  rate = ctrl[`BRT_CTRL_RATE_LSB+:3];
	wire         tx_step = enable && i_tx_bit_en;
	wire         tx_pat = brt_out(tx_gen, tx_cfg[4:0], tx_cfg[12:8],
		tx_cfg[`BRT_PCFG_PTS], tx_cfg[`BRT_PCFG_QRSS]);
	wire         tx_fb = brt_fb(tx_gen, tx_cfg[4:0], tx_cfg[12:8],
		tx_cfg[`BRT_PCFG_PTS], tx_cfg[`BRT_PCFG_QRSS]);
	wire         rate_hit = rate != 3'h0
		&& rate_cnt >= brt_period(rate);
	// Source select picks register write or pin edge
	wire         one_new = ctrl[`BRT_CTRL_ERR_PIN] ? pin_rise
		: one_err_req;
	wire         flip = rate_hit || err_pend || one_new;

	// One outgoing bit per strobe; a new request wins over consumption
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			tx_gen     <= 32'hFFFFFFFF;
			tx_cfg     <= `BRT_PCFG_RST;
			rate_cnt   <= 24'h000000;
			err_pend   <= 1'b0;
			o_tx_data  <= 1'b0;
			o_tx_valid <= 1'b0;
		end
		else
		begin
			o_tx_valid <= tx_step;
			// A request met by a bit is spent on it; a pending one wins
			// that bit and the new request waits for the next
			err_pend <= tx_step ? (err_pend && one_new)
				: (err_pend || one_new);
			if (tx_load_pls)
			begin
				tx_gen   <= seed;
				tx_cfg   <= pcfg;
				rate_cnt <= 24'h000000;
			end
			else if (tx_step)
			begin
				tx_gen    <= {tx_gen[30:0], tx_fb};
				o_tx_data <= tx_pat ^ ctrl[`BRT_CTRL_TX_INV]
					^ flip;
				rate_cnt  <= rate_hit ? 24'h000000
					: rate_cnt + 24'h000001;
			end
		end
	end

	// ----------------------------------------------------------------
	// Receive synchronisation and checking
	// ----------------------------------------------------------------
	brt_sync_e   state;
	logic [31:0] rx_gen;
	logic [5:0]  run_cnt;
	logic [5:0]  win_cnt;
	logic [2:0]  win_errs;
	logic [BCNT_W-1:0] bit_cnt;
	logic [ECNT_W-1:0] err_cnt;

	wire rx_step = enable && i_rx_bit_en;
	wire rx_bit = i_rx_data ^ ctrl[`BRT_CTRL_RX_INV];
	wire rx_pts = rx_cfg[`BRT_PCFG_PTS];
	wire rx_exp = brt_out(rx_gen, rx_cfg[4:0], rx_cfg[12:8],
		rx_pts, rx_cfg[`BRT_PCFG_QRSS]);
	wire rx_fb = brt_fb(rx_gen, rx_cfg[4:0], rx_cfg[12:8],
		rx_pts, rx_cfg[`BRT_PCFG_QRSS]);
	wire miss = rx_bit != rx_exp;
	wire [31:0] rx_adv = {rx_gen[30:0], rx_fb};
	wire [5:0]  rep_need = {1'b0, rx_cfg[4:0]} + 6'h01;
	wire in_sync = state == BRT_SYNC;
	wire count_en = rx_step && in_sync;
	// Sixth error of the window drops sync unless restart is off
	wire lose = in_sync && rx_step && miss
		&& win_errs == `BRT_LOSS_ERRS - 3'h1
		&& !ctrl[`BRT_CTRL_NO_RESYNC];

	// Sync machine: disabled or reloaded means a fresh search
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			state    <= BRT_SEARCH;
			rx_gen   <= 32'hFFFFFFFF;
			rx_cfg   <= `BRT_PCFG_RST;
			rx_seed  <= 32'hFFFFFFFF;
			run_cnt  <= 6'h00;
			win_cnt  <= 6'h00;
			win_errs <= 3'h0;
		end
		else if (rx_load_pls || !enable)
		begin
			if (rx_load_pls)
			begin
				rx_cfg  <= pcfg;
				rx_seed <= seed;
				rx_gen  <= seed;
			end
			else
				rx_gen <= rx_seed;
			state   <= BRT_SEARCH;
			run_cnt <= 6'h00;
		end
		else if (rx_step)
		begin
			unique case (state)
				BRT_SEARCH:
				begin
					if (!rx_pts)
					begin
						// Fill the generator from the line
						rx_gen  <= {rx_gen[30:0], rx_bit};
						run_cnt <= run_cnt + 6'h01;
						if (run_cnt == `BRT_SYNC_BITS - 6'h01)
						begin
							state   <= BRT_VERIFY;
							run_cnt <= 6'h00;
						end
					end
					else if (miss)
						// Hold the pattern: slips one position
						run_cnt <= 6'h00;
					else
					begin
						rx_gen  <= rx_adv;
						run_cnt <= run_cnt + 6'h01;
						if (run_cnt == rep_need - 6'h01)
						begin
							state   <= BRT_VERIFY;
							run_cnt <= 6'h00;
						end
					end
				end
				BRT_VERIFY:
				begin
					rx_gen  <= rx_adv;
					run_cnt <= run_cnt + 6'h01;
					if (miss)
					begin
						state   <= BRT_SEARCH;
						run_cnt <= 6'h00;
					end
					else if (run_cnt == `BRT_SYNC_BITS - 6'h01)
					begin
						state    <= BRT_SYNC;
						win_cnt  <= 6'h00;
						win_errs <= 3'h0;
					end
				end
				BRT_SYNC:
				begin
					rx_gen  <= rx_adv;
					win_cnt <= win_cnt + 6'h01;
					if (lose)
					begin
						state   <= BRT_SEARCH;
						run_cnt <= 6'h00;
					end
					if (win_cnt == `BRT_WIN_LAST)
						win_errs <= 3'h0;
					else if (miss && win_errs != `BRT_LOSS_ERRS)
						win_errs <= win_errs + 3'h1;
				end
				// Fourth code of the state word is never entered
				default:
					state <= BRT_SEARCH;
			endcase
		end
	end

	// Running counters; a bit arriving with the update is not lost
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			bit_cnt            <= '0;
			err_cnt            <= '0;
			rx_bit_count_reg   <= '0;
			rx_error_count_reg <= '0;
			o_out_of_sync_flag <= 1'b1;
		end
		else
		begin
			o_out_of_sync_flag <= !in_sync;
			if (latch_pls)
			begin
				rx_bit_count_reg   <= bit_cnt;
				rx_error_count_reg <= err_cnt;
				bit_cnt <= BCNT_W'(count_en);
				err_cnt <= ECNT_W'(count_en && miss);
			end
			else if (count_en)
			begin
				bit_cnt <= bit_cnt + 1'b1;
				if (miss)
					err_cnt <= err_cnt + 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Read side
	// ----------------------------------------------------------------
	logic [DATA_W-1:0] rd_mux;
	wire bit_error_flag = err_cnt != '0;

	// Unmapped offsets read as zero
	always_comb
	begin
		rd_mux = '0;
		case (i_addr)
			`BRT_OFS_ROUTE:   rd_mux[0] = enable;
			`BRT_OFS_PCFG:    rd_mux[12:0] = pcfg;
			`BRT_OFS_SEED_LO: rd_mux[15:0] = seed_low_half;
			`BRT_OFS_SEED_HI: rd_mux[15:0] = seed_high_half;
			`BRT_OFS_CTRL:    rd_mux[10:0] = ctrl;
			`BRT_OFS_STATUS:
			begin
				rd_mux[`BRT_STAT_BIT_ERR] = bit_error_flag;
				rd_mux[`BRT_STAT_OOS]     = !in_sync;
			end
			`BRT_OFS_BIT_CNT: rd_mux[BCNT_W-1:0] = rx_bit_count_reg;
			`BRT_OFS_ERR_CNT: rd_mux[ECNT_W-1:0] = rx_error_count_reg;
			default:          rd_mux = '0;
		endcase
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			o_rdata <= '0;
		else
			o_rdata <= i_rd ? rd_mux : '0;
	end

endmodule

/* bench/brt_props.sv */
// Checker for the tester's port behaviour.
// Assumes it is bound onto brt_tester and sees only its ports.
`timescale 1ns/1ps
`include "brt_consts.svh"

module brt_props
#(
	parameter int DATA_W = 32,
	parameter int BCNT_W = 32,
	parameter int ECNT_W = 24
)
(
	input wire logic                   i_clk,
	input wire logic                   i_rstn,
	input wire logic [`BRT_ADDR_W-1:0] i_addr,
	input wire logic [DATA_W-1:0]      i_wdata,
	input wire logic                   i_wr,
	input wire logic                   i_rd,
	input wire logic [DATA_W-1:0]      o_rdata,
	input wire logic                   i_tx_bit_en,
	input wire logic                   o_tx_data,
	input wire logic                   o_tx_valid,
	input wire logic                   i_rx_bit_en,
	input wire logic                   i_rx_data,
	input wire logic                   i_manual_error_input,
	input wire logic                   o_out_of_sync_flag
);
	logic       en_q;
	logic       pts_q;
	logic [7:0] rx_seen;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rstn);

	// Mirror of the enable bit, taken from the register writes
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			en_q <= 1'b0;
		else if (i_wr && i_addr == `BRT_OFS_ROUTE)
			en_q <= i_wdata[`BRT_ROUTE_EN];
	end

	// Mirror of the repetitive select, taken from the register writes
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			pts_q <= 1'b0;
		else if (i_wr && i_addr == `BRT_OFS_PCFG)
			pts_q <= i_wdata[`BRT_PCFG_PTS];
	end

	// Bits seen while unsynchronised; the flag lags the state by one clock,
	// so one bit may go unseen and the bound below is 63, not 64
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			rx_seen <= 8'h00;
		else if (!o_out_of_sync_flag)
			rx_seen <= 8'h00;
		else if (i_rx_bit_en && rx_seen != 8'hFF)
			rx_seen <= rx_seen + 8'h01;
	end

	sequence s_seed_wr;
		i_wr && i_addr == `BRT_OFS_SEED_LO;
	endsequence

	sequence s_seed_rd;
		i_rd && i_addr == `BRT_OFS_SEED_LO;
	endsequence

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	a_tx_gated_off: assert property (
		!en_q && i_tx_bit_en |=> !o_tx_valid)
		else $error("bit answered while disabled");
	a_tx_bit_answer: assert property (
		en_q && i_tx_bit_en |=> o_tx_valid)
		else $error("bit request not answered");
	a_tx_valid_cause: assert property (
		o_tx_valid |-> $past(i_tx_bit_en))
		else $error("bit valid without request");
	a_status_oos: assert property (
		i_rd && i_addr == `BRT_OFS_STATUS |=>
		o_rdata[`BRT_STAT_OOS] == o_out_of_sync_flag)
		else $error("status and sync flag disagree");
	a_sync_on_bit: assert property (
		$fell(o_out_of_sync_flag) |-> $past(i_rx_bit_en, 2))
		else $error("sync gained without a bit");
	a_sync_bit_count: assert property (
		$fell(o_out_of_sync_flag) && !pts_q |-> rx_seen >= 8'd63)
		else $error("sync gained too early");
	a_rep_sync_count: assert property (
		$fell(o_out_of_sync_flag) && pts_q |-> rx_seen >= 8'd33)
		else $error("repetitive sync gained too early");
	a_err_cnt_width: assert property (
		i_rd && i_addr == `BRT_OFS_ERR_CNT |=> o_rdata[31:24] == 8'h00)
		else $error("error count wider than 24 bits");
	a_seed_readback: assert property (
		s_seed_wr ##1 s_seed_rd |=>
		o_rdata[15:0] == $past(i_wdata[15:0], 2) && o_rdata[31:16] == 16'h0)
		else $error("seed low half read back wrong");
	a_rdata_idle: assert property (
		!i_rd |=> o_rdata == '0)
		else $error("read data outside read cycle");
endmodule

/* bench/brt_line_model.sv */
// Line-side model: requests transmit bits and loops them back as receive.
// Assumes the tester's single clock; the bench steers run and flip.
`timescale 1ns/1ps

module brt_line_model
(
	input  wire logic i_clk,
	input  wire logic i_rstn,
	input  wire logic i_run,
	input  wire logic i_flip,
	input  wire logic i_tx_data,
	input  wire logic i_tx_valid,
	output logic      o_tx_bit_en,
	output logic      o_rx_bit_en,
	output logic      o_rx_data
);
	// One bit request per cycle while running; each answered bit returns
	// a cycle later. Between bits the data line toggles every cycle, starting
	// from the inverse of the last bit, so it does not sit on a stale value.
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			o_tx_bit_en <= 1'b0;
			o_rx_bit_en <= 1'b0;
			o_rx_data   <= 1'b0;
		end
		else
		begin
			o_tx_bit_en <= i_run;
			o_rx_bit_en <= i_tx_valid;
			o_rx_data   <= i_tx_valid ? (i_tx_data ^ i_flip) : ~o_rx_data;
		end
	end
endmodule

/* bench/test_bit_error_rate_tester.sv */
// Self-checking bench for the tester with a loop-back line model.
// Assumes brt_consts.svh offsets; the line model closes the loop.
`timescale 1ns/1ps
`include "brt_consts.svh"

module test_bit_error_rate_tester;
	logic        clk   = 1'b0;
	logic        rstn  = 1'b0;
	logic [7:0]  addr  = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic        wr    = 1'b0;
	logic        rd    = 1'b0;
	logic        pin   = 1'b0;
	logic        run   = 1'b0;
	logic        flip  = 1'b0;
	logic [31:0] rdata;
	logic        tx_bit_en;
	logic        tx_data;
	logic        tx_valid;
	logic        rx_bit_en;
	logic        rx_data;
	logic        out_of_sync_flag;
	int          mismatches = 0;
	int          cmp_count  = 0;

	always #4 clk = ~clk;

	brt_tester dut_u (.i_clk(clk), .i_rstn(rstn), .i_addr(addr),
		.i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
		.i_tx_bit_en(tx_bit_en), .o_tx_data(tx_data),
		.o_tx_valid(tx_valid), .i_rx_bit_en(rx_bit_en),
		.i_rx_data(rx_data), .i_manual_error_input(pin),
		.o_out_of_sync_flag(out_of_sync_flag));

	brt_line_model u_line (.i_clk(clk), .i_rstn(rstn), .i_run(run),
		.i_flip(flip), .i_tx_data(tx_data), .i_tx_valid(tx_valid),
		.o_tx_bit_en(tx_bit_en), .o_rx_bit_en(rx_bit_en),
		.o_rx_data(rx_data));

	// ----------------------------------------------------------------
	// Compare and bus tasks; the bus tasks start just after a rising edge
	// ----------------------------------------------------------------
	task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			mismatches++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic chk_bit(input logic got, input logic exp);
		chk32({31'h0, got}, {31'h0, exp});
	endtask

	// A gap edge follows each strobe so no strobe is driven twice at once
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr    <= 1'b0;
		@(posedge clk);
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd   <= 1'b0;
		#1;
		chk32(rdata, exp);
		@(posedge clk);
	endtask

	task automatic wait_oos(input logic v, output int n);
		n = 0;
		while (out_of_sync_flag !== v && n < 200)
		begin
			@(negedge clk);
			n++;
		end
		@(posedge clk);
	endtask

	task automatic give_verdict;
		$display("compares %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset;
		rd_chk(`BRT_OFS_STATUS, 32'h2);
		rd_chk(`BRT_OFS_SEED_HI, 32'hFFFF);
		wr_reg(`BRT_OFS_BIT_CNT, 32'h1234);
		rd_chk(`BRT_OFS_BIT_CNT, 32'h0);
		rd_chk(8'h24, 32'h0);
		// Write then read back to back, with no gap edge
		addr  <= `BRT_OFS_SEED_LO;
		wdata <= 32'h0000A5C3;
		wr    <= 1'b1;
		@(posedge clk);
		wr    <= 1'b0;
		rd    <= 1'b1;
		@(posedge clk);
		rd    <= 1'b0;
		#1;
		chk32(rdata, 32'h0000A5C3);
		@(posedge clk);
	endtask

	// Bits requested while disabled must not be answered
	task automatic t_off;
		int v;
		v = 0;
		wr_reg(`BRT_OFS_PCFG, 32'h0D0E);
		wr_reg(`BRT_OFS_SEED_LO, 32'hFFFF);
		wr_reg(`BRT_OFS_SEED_HI, 32'hFFFF);
		run <= 1'b1;
		repeat (20)
		begin
			@(negedge clk);
			if (tx_valid === 1'b1)
				v++;
		end
		@(posedge clk);
		run <= 1'b0;
		chk32(32'(v), 32'h0);
		wr_reg(`BRT_OFS_ROUTE, 32'h1);
	endtask

	// Reference generator: n=15, y=14, seed all ones, rate 1 in 10
	task automatic t_tx(input logic inv, input logic [2:0] rate);
		logic [31:0] g;
		logic        fb;
		int          k;
		g = 32'hFFFFFFFF;
		k = 0;
		wr_reg(`BRT_OFS_CTRL, {21'h0, rate, 4'h0, inv, 3'h0});
		wr_reg(`BRT_OFS_CTRL, {21'h0, rate, 4'h0, inv, 3'h1});
		run <= 1'b1;
		while (k < 30)
		begin
			@(negedge clk);
			if (tx_valid === 1'b1)
			begin
				k++;
				fb = g[14] ^ g[13];
				if (g[30:0] == 31'h0)
					fb = 1'b1;
				g = {g[30:0], fb};
				chk_bit(tx_data, fb ^ inv ^ (rate != 3'h0 && k % 10 == 0));
			end
		end
		@(posedge clk);
		run <= 1'b0;
	endtask

	// Sync, then count one register error and one pin error
	task automatic t_sync;
		int n;
		wr_reg(`BRT_OFS_CTRL, 32'h0);
		wr_reg(`BRT_OFS_CTRL, 32'h3);
		run <= 1'b1;
		wait_oos(1'b0, n);
		chk_bit(n >= 68 && n <= 70, 1'b1);
		wr_reg(`BRT_OFS_CTRL, 32'h7);
		wr_reg(`BRT_OFS_CTRL, 32'h27);
		repeat (10) @(posedge clk);
		rd_chk(`BRT_OFS_STATUS, 32'h1);
		wr_reg(`BRT_OFS_CTRL, 32'h3);
		wr_reg(`BRT_OFS_CTRL, 32'h7);
		rd_chk(`BRT_OFS_ERR_CNT, 32'h1);
		rd_chk(`BRT_OFS_BIT_CNT, 32'd18);
		rd_chk(`BRT_OFS_STATUS, 32'h0);
		wr_reg(`BRT_OFS_CTRL, 32'h47);
		wr_reg(`BRT_OFS_CTRL, 32'h67);
		pin <= 1'b1;
		repeat (8) @(posedge clk);
		pin <= 1'b0;
		repeat (8) @(posedge clk);
		wr_reg(`BRT_OFS_CTRL, 32'h43);
		wr_reg(`BRT_OFS_CTRL, 32'h47);
		rd_chk(`BRT_OFS_ERR_CNT, 32'h1);
	endtask

	// Twelve straight bad bits put six in one window whatever its phase
	task automatic t_loss;
		int n;
		flip <= 1'b1;
		repeat (12) @(posedge clk);
		flip <= 1'b0;
		wait_oos(1'b1, n);
		chk_bit(out_of_sync_flag, 1'b1);
		wait_oos(1'b0, n);
		chk_bit(out_of_sync_flag, 1'b0);
		wr_reg(`BRT_OFS_CTRL, 32'h87);
		flip <= 1'b1;
		repeat (12) @(posedge clk);
		flip <= 1'b0;
		repeat (30) @(posedge clk);
		chk_bit(out_of_sync_flag, 1'b0);
	endtask

	// Alternating repetitive pattern: two-bit search, then 32 checks
	task automatic t_rep;
		int n;
		run <= 1'b0;
		wr_reg(`BRT_OFS_PCFG, 32'h0021);
		wr_reg(`BRT_OFS_SEED_HI, 32'hFFFF);
		wr_reg(`BRT_OFS_SEED_LO, 32'hFFFE);
		wr_reg(`BRT_OFS_CTRL, 32'h4);
		wr_reg(`BRT_OFS_CTRL, 32'h7);
		wait_oos(1'b1, n);
		run <= 1'b1;
		wait_oos(1'b0, n);
		chk_bit(n >= 38 && n <= 40, 1'b1);
	endtask

	// ----------------------------------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------------------------------
	initial
	begin
		repeat (10) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		t_reset;
		t_off;
		t_tx(1'b0, 3'h1);
		t_tx(1'b1, 3'h0);
		t_sync;
		t_loss;
		t_rep;
		give_verdict;
	end

	// Whole run is a few hundred cycles; this is far beyond it
	initial
	begin
		#200000;
		mismatches++;
		give_verdict;
	end
endmodule

bind brt_tester brt_props #(.DATA_W(DATA_W), .BCNT_W(BCNT_W),
	.ECNT_W(ECNT_W)) u_props (.i_clk(i_clk), .i_rstn(i_rstn),
	.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
	.o_rdata(o_rdata), .i_tx_bit_en(i_tx_bit_en), .o_tx_data(o_tx_data),
	.o_tx_valid(o_tx_valid), .i_rx_bit_en(i_rx_bit_en),
	.i_rx_data(i_rx_data), .i_manual_error_input(i_manual_error_input),
	.o_out_of_sync_flag(o_out_of_sync_flag));
